// ==== load_result_map.vh ====
// register map and field layout of the motor load result bank
// assumes a 32-bit avalon-mm slave with byte addresses, four per register index
`ifndef LOAD_RESULT_MAP_VH
`define LOAD_RESULT_MAP_VH

// ****************************************************************
// register indices, byte address is four times the index
// ****************************************************************
`define IDX_LOAD_CONTROL      7'h74
`define IDX_LOAD_RESULT       7'h75
`define IDX_LOAD_SAMPLES      7'h76

// ****************************************************************
// field positions
// ****************************************************************
`define FLD_FILTER_EN         8
`define FLD_RESULT_MSB        9
`define FLD_RESULT_LSB        0
`define FLD_SAMPLE_W          8

// ****************************************************************
// reset values
// ****************************************************************
`define RST_LOAD_CONTROL      32'h00000000
`define RST_LOAD_RESULT       10'h000
`define RST_LOAD_SAMPLES      32'h00000000
`define RST_SAMPLE            8'h00

`endif

// ==== load_filter.v ====
// four-tap moving average over the raw load samples
// assumes one sample per full step on sample_strobe, synchronous to clk_sys
module load_filter #(
   parameter SAMPLE_W = 8
) (
   input  wire                  clk_sys,
   input  wire                  nrst,
   input  wire                  sample_strobe,
   input  wire [SAMPLE_W-1:0]   sample_in,
   output reg  [SAMPLE_W-1:0]   hist_one,
   output reg  [SAMPLE_W-1:0]   hist_two,
   output reg  [SAMPLE_W-1:0]   hist_three,
   output wire [SAMPLE_W-1:0]   average
);

   wire [SAMPLE_W+1:0] sum;

   // history keeps shifting with the filter off, so enabling it gives a full window at once
   assign sum = {2'b00, sample_in} + {2'b00, hist_one} + {2'b00, hist_two}
              + {2'b00, hist_three};
   assign average = sum[SAMPLE_W+1:2];

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         hist_one   <= {SAMPLE_W{1'b0}};
         hist_two   <= {SAMPLE_W{1'b0}};
         hist_three <= {SAMPLE_W{1'b0}};
      end else if (sample_strobe) begin
         hist_one   <= sample_in;
         hist_two   <= hist_one;
         hist_three <= hist_two;
      end
   end

endmodule // load_filter

// ==== avalon_word_slave.v ====
// avalon-mm front end: one wait state, registered readdata and waitrequest
// assumes the master holds the request until it samples waitrequest low
module avalon_word_slave (
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] read_value,
   output reg         waitrequest,
   output reg  [31:0] readdata,
   output wire        write_fire
);

   // a write lands only at the edge that ends the transfer, where waitrequest is seen low
   assign write_fire = write & ~waitrequest;

   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h00000000;
      end else begin
         if ((read | write) & waitrequest) begin
            waitrequest <= 1'b0;
            readdata    <= read ? read_value : 32'h00000000;
         end else begin
            waitrequest <= 1'b1;
         end
      end
   end

endmodule // avalon_word_slave

// ==== motor_load_result_regs.v ====
// read-only load measurement result and filter sample registers of one axis
// assumes a raw load sample with a full-step strobe from the measurement front end
//
// Chosen here: the Avalon-MM interface to the registers.
`include "load_result_map.vh"

module motor_load_result_regs #(
   parameter SAMPLE_W = 8,
   parameter ADDR_W   = 9
) (
   input  wire              clk_sys,
   input  wire              nrst,
   input  wire [ADDR_W-1:0] address,
   input  wire              read,
   input  wire              write,
   input  wire [31:0]       writedata,
   input  wire [3:0]        byteenable,
   output wire [31:0]       readdata,
   output wire              waitrequest,
   input  wire              full_step,
   input  wire [7:0]        load_sample,
   output reg               load_filter_enable
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   // eight significant bits sit in 8:1 so the range matches the older method
   function [9:0] scale_result;
      input [7:0] s;
      begin
         scale_result = {1'b0, s, 1'b0};
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   reg  [9:0]  load_measure_result;
   reg  [7:0]  load_sample_zero;
   reg  [7:0]  load_sample_one;
   reg  [7:0]  load_sample_two;
   reg  [7:0]  load_sample_three;
   reg  [31:0] read_value;
   wire        write_fire;
   wire [7:0]  hist_one;
   wire [7:0]  hist_two;
   wire [7:0]  hist_three;
   wire [7:0]  average;
   wire [6:0]  index;

   assign index = address[8:2];

   load_filter #(
      .SAMPLE_W (8)
   ) u_filter (
      .clk_sys       (clk_sys),
      .nrst          (nrst),
      .sample_strobe (full_step),
      .sample_in     (load_sample),
      .hist_one      (hist_one),
      .hist_two      (hist_two),
      .hist_three    (hist_three),
      .average       (average)
   );

   avalon_word_slave u_bus (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .read        (read),
      .write       (write),
      .read_value  (read_value),
      .waitrequest (waitrequest),
      .readdata    (readdata),
      .write_fire  (write_fire)
   );

   // ****************************************************************
   // control register, the only writable bit
   // ****************************************************************
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         load_filter_enable <= 1'b0;
      end else if (write_fire && index == `IDX_LOAD_CONTROL && byteenable[1]) begin
         load_filter_enable <= writedata[`FLD_FILTER_EN];
      end
   end

   // ****************************************************************
   // load measurement result
   // ****************************************************************
   // the front end already reports larger samples for lighter load, no inversion here
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         load_measure_result <= `RST_LOAD_RESULT;
      end else if (full_step) begin
         if (load_filter_enable) begin
            load_measure_result <= scale_result(average);
         end else begin
            load_measure_result <= scale_result(load_sample);
         end
      end
   end

   // ****************************************************************
   // filter sample fields
   // ****************************************************************
   // upper fields load zero at each full step with the filter off, they carry no meaning then
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         load_sample_zero  <= `RST_SAMPLE;
         load_sample_one   <= `RST_SAMPLE;
         load_sample_two   <= `RST_SAMPLE;
         load_sample_three <= `RST_SAMPLE;
      end else if (full_step) begin
         load_sample_zero <= load_sample;
         if (load_filter_enable) begin
            load_sample_one   <= hist_one;
            load_sample_two   <= hist_two;
            load_sample_three <= hist_three;
         end else begin
            load_sample_one   <= `RST_SAMPLE;
            load_sample_two   <= `RST_SAMPLE;
            load_sample_three <= `RST_SAMPLE;
         end
      end
   end

   // ****************************************************************
   // read decode, unmapped reads return zero, writes to read-only ignored
   // ****************************************************************
   always @* begin
      read_value = 32'h00000000;
      case (index)
         `IDX_LOAD_CONTROL: read_value[`FLD_FILTER_EN] = load_filter_enable;
         `IDX_LOAD_RESULT:  read_value = {22'h000000, load_measure_result};
         `IDX_LOAD_SAMPLES: begin
            read_value = {load_sample_three, load_sample_two,
                          load_sample_one, load_sample_zero};
         end
         default:           read_value = 32'h00000000;
      endcase
   end

endmodule // motor_load_result_regs

// ==== load_result_chk_props.sv ====
// checker: bus timing and field relations of the load result bank
// assumes one clock domain, bound into motor_load_result_regs
module load_result_chk #(
   parameter SAMPLE_W = 8,
   parameter ADDR_W   = 9
) (
   input wire              clk_sys,
   input wire              nrst,
   input wire [ADDR_W-1:0] address,
   input wire              read,
   input wire              write,
   input wire [31:0]       readdata,
   input wire              waitrequest,
   input wire              full_step,
   input wire [7:0]        load_sample,
   input wire              load_filter_enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // shadow history shifts on every step, filter on or off
   reg [7:0] s0, s1, s2;
   reg       lf;
   wire rr = read && !waitrequest;
   wire rr_res = rr && address[8:2] == 7'h75;
   wire rr_smp = rr && address[8:2] == 7'h76;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) {s0, s1, s2, lf} <= 25'h0000000;
      else if (full_step) {s0, s1, s2, lf} <= {load_sample, s0, s1, load_filter_enable};
   end
   // ****************************************
   // assertions
   // ****************************************
   property p_res_bits; rr_res |-> !readdata[9] && !readdata[0]; endproperty
   a_res_bits: assert property (p_res_bits) else $error("result edge bits set");
   property p_res_up; rr_res |-> readdata[31:10] == 22'h000000; endproperty
   a_res_up: assert property (p_res_up) else $error("result upper bits set");
   property p_res_val; rr_res && !$past(lf) |-> readdata[9:0] == {1'b0, $past(s0), 1'b0};
   endproperty
   a_res_val: assert property (p_res_val) else $error("result value");
   property p_smp_low; rr_smp |-> readdata[7:0] == $past(s0); endproperty
   a_smp_low: assert property (p_smp_low) else $error("sample zero");
   property p_smp_hist;
      rr_smp && $past(lf) && load_filter_enable |-> readdata[23:8] == {$past(s2), $past(s1)};
   endproperty
   a_smp_hist: assert property (p_smp_hist) else $error("sample history");
   property p_rd_hold; !read && !write |=> $stable(readdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
   property p_one_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
   a_one_wait: assert property (p_one_wait) else $error("no answer");
   property p_wait_pulse; !waitrequest |=> waitrequest; endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
   c_res: cover property (rr_res);
   c_filt: cover property (rr_smp && load_filter_enable);
   c_step: cover property (full_step && load_filter_enable);
endmodule // load_result_chk

bind motor_load_result_regs load_result_chk #(.SAMPLE_W(SAMPLE_W), .ADDR_W(ADDR_W)) u_chk (
   .clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read), .write(write),
   .readdata(readdata), .waitrequest(waitrequest), .full_step(full_step),
   .load_sample(load_sample), .load_filter_enable(load_filter_enable));

// ==== motor_load_result_regs_tb.sv ====
// testbench: avalon-mm reads and full-step pulses into the load result bank
// assumes design files compiled first, checker bound on its own
module motor_load_result_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [8:0]  address = 9'h000;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic        full_step = 1'b0;
   logic [7:0]  load_sample = 8'h00;
   wire  [31:0] readdata;
   wire         waitrequest;
   wire         load_filter_enable;
   int          mismatches = 0;
   int          check_count = 0;
   logic [31:0] q;
   motor_load_result_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
      .readdata(readdata), .waitrequest(waitrequest), .full_step(full_step),
      .load_sample(load_sample), .load_filter_enable(load_filter_enable));
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // idle edge at the end so back-to-back calls never assign read twice in a step
   // no cycle limit: a slave that never answers is left to the watchdog
   task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      read <= !w;
      write <= w;
      @(posedge clk_sys);
      while (waitrequest !== 1'b0) @(posedge clk_sys);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic step(input logic [7:0] s);
      full_step <= 1'b1;
      load_sample <= s;
      @(posedge clk_sys);
      full_step <= 1'b0;
      @(posedge clk_sys);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      check("wait idle", {31'h0, waitrequest}, 32'h1);
      check("enable", {31'h0, load_filter_enable}, 32'h0);
      bus(0, 9'h1D4, 32'h0);
      check("result", q, 32'h0);
      bus(0, 9'h1D8, 32'h0);
      check("samples", q, 32'h0);
      bus(0, 9'h004, 32'h0);
      check("unmapped", q, 32'h0);
   endtask
   // samples stand for a motor in the quiet chopper, the only mode the result serves
   task automatic t_plain;
      logic [7:0] v[4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
      foreach (v[i]) begin
         step(v[i]);
         bus(0, 9'h1D4, 32'h0);
         check("result", q, {23'h0, v[i], 1'b0});
         bus(0, 9'h1D8, 32'h0);
         check("samples", q, {24'h0, v[i]});
      end
      bus(1, 9'h1D4, 32'hFFFFFFFF);
      bus(0, 9'h1D4, 32'h0);
      check("ro result", q, 32'h000001FE);
   endtask
   // newest sample in the low byte, oldest in the top byte
   task automatic t_filter;
      bus(1, 9'h1D0, 32'h00000100);
      check("enable", {31'h0, load_filter_enable}, 32'h1);
      bus(0, 9'h1D0, 32'h0);
      check("control", q, 32'h00000100);
      step(8'h11);
      step(8'h22);
      step(8'h33);
      step(8'h44);
      bus(0, 9'h1D8, 32'h0);
      check("samples", q, 32'h11223344);
      bus(0, 9'h1D8, 32'h0);
      check("held", q, 32'h11223344);
      bus(0, 9'h1D4, 32'h0);
      check("filtered", q, 32'h00000054);
   endtask
   task automatic t_rerun;
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      check("enable", {31'h0, load_filter_enable}, 32'h0);
      check("wait idle", {31'h0, waitrequest}, 32'h1);
      bus(0, 9'h1D4, 32'h0);
      check("result", q, 32'h0);
      bus(0, 9'h1D8, 32'h0);
      check("samples", q, 32'h0);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_plain();
      t_filter();
      t_rerun();
      summarize();
   end
   initial begin
      #100000;
      mismatches++;
      summarize();
   end
endmodule // motor_load_result_regs_tb
